// [verilog/acr_defs.vh]
// register indices, field positions, reset values and codes of the block
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ====================================================================
// register indices (byte address = index * 4)
`define ACR_IDX_CTRL_A      8'h02
`define ACR_IDX_CTRL_B      8'h03
`define ACR_IDX_CTRL_C      8'h04
`define ACR_IDX_LOW_EN      8'h05
`define ACR_IDX_IRQ_STATUS  8'h06
`define ACR_IDX_IRQ_CLEAR   8'h07
`define ACR_IDX_IRQ_ENABLE  8'h08
`define ACR_IDX_MISC        8'h09

// ====================================================================
// reset values
`define ACR_RST_CTRL_A      16'h0FF0
`define ACR_RST_CTRL_B      16'h0140
`define ACR_RST_CTRL_C      16'hFFFF
`define ACR_RST_LOW_EN      16'h0000

// ====================================================================
// field positions
`define ACR_SKIP_MSB        3
`define ACR_FP_HOLD_LSB     4
`define ACR_LP_HOLD_LSB     8
`define ACR_TIMEOUT_LSB     12
`define ACR_FORCE_CAL_BIT   14
`define ACR_RESTART_BIT     15
`define ACR_STAGES          12
`define ACR_GPIO_EV_BIT     12
`define ACR_GPIO_SETUP_LSB  12
`define ACR_GPIO_TRIG_LSB   14

// ====================================================================
// codes and scale factors
`define ACR_SKIP_MAX        4'hB
`define ACR_FP_HOLD_SCALE   4
`define ACR_LP_HOLD_SCALE   2
`define ACR_GPIO_OFF        2'h0
`define ACR_GPIO_IN         2'h1
`define ACR_GPIO_OUT_LOW    2'h2
`define ACR_GPIO_OUT_HIGH   2'h3
`define ACR_TRIG_LOW        2'h0
`define ACR_TRIG_RISE       2'h1
`define ACR_TRIG_FALL       2'h2
`define ACR_TRIG_HIGH       2'h3
`define ACR_RESP_OKAY       2'h0
`define ACR_RESP_SLVERR     2'h2

`endif

// [verilog/acr_regs.v]
// ambient compensation and low-threshold interrupt configuration registers
//
// Function
// - skip field discards sequences before fast admission
// - full power hold: count times 16 sequences
// - low power hold: count times 4 sequences
// - timeout selects 1.25 to 2.00 hold
// - bit 14 forces all stages recalibrate
// - bit 15 restarts sequence, then self-clears
// - second register: level, rate, slow update
// - third register: full and low recal times
// - enable bits gate stage low interrupts
// - setup field configures general-purpose pin
// - trigger field selects level or edge event
// - polarity bit sets interrupt active level
`include "acr_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module acr_regs #(
  parameter ADDR_W = 8                  // axi address width
) (
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite slave
  input  wire [ADDR_W-1:0] awaddr,
  input  wire              awvalid,
  output reg               awready,
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output reg               wready,
  output reg  [1:0]        bresp,
  output reg               bvalid,
  input  wire              bready,
  input  wire [ADDR_W-1:0] araddr,
  input  wire              arvalid,
  output reg               arready,
  output reg  [31:0]       rdata,
  output reg  [1:0]        rresp,
  output reg               rvalid,
  input  wire              rready,
  // sequencer and calibration side
  input  wire              seq_done,
  input  wire              lp_mode,
  input  wire              near_detect,
  input  wire [11:0]       stage_low_hit,
  output reg               fast_admit,
  output reg  [3:0]        fast_filter_skip_count,
  output reg               cal_suspend,
  output reg               power_drop_request,
  output reg               force_recal,
  output reg               sequence_restart,
  output reg  [7:0]        near_recal_level,
  output reg  [5:0]        near_detect_rate,
  output reg  [1:0]        slow_average_update_level,
  output reg  [9:0]        full_power_near_recal_time,
  output reg  [5:0]        low_power_near_recal_time,
  // general-purpose pin and interrupt
  input  wire              gpio_in,
  input  wire              gpio_assert,
  output reg               gpio_out,
  output reg               gpio_oe,
  output reg               irq
);

  // ==================================================================
  // decode helper
  // word index of a byte address
  function [7:0] word_index;
    input [ADDR_W-1:0] addr;
    begin
      word_index = {{(8 + 2 - ADDR_W){1'b0}}, addr[ADDR_W-1:2]};
    end
  endfunction

  // ==================================================================
  // storage
  reg  [15:0]       ctrl_a;               // ambient control a
  reg  [15:0]       ctrl_b;               // ambient control b
  reg  [15:0]       ctrl_c;               // ambient control c
  reg  [15:0]       low_en;               // low irq enable and gpio
  reg  [12:0]       irq_status;           // sticky events
  reg               gpio_ev_en;           // gpio event enable
  reg               irq_polarity;         // 1 = active high
  reg               aw_full;              // write address held
  reg               w_full;               // write data held
  reg  [ADDR_W-1:0] aw_addr;              // held write address
  reg  [31:0]       w_data;               // held write data
  reg  [3:0]        w_strb;               // held byte enables
  reg  [3:0]        skip_cnt;             // sequences skipped so far
  reg  [8:0]        hold_cnt;             // calibration hold left
  reg  [8:0]        idle_cnt;             // full power idle sequences
  reg               gpio_meta;            // sync stage one
  reg               gpio_sync;            // sync stage two
  reg               gpio_prev;            // previous synced level

  // ==================================================================
  // bus handshake terms
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire ar_take  = arvalid & arready;
  wire do_write = aw_full & w_full & ~bvalid;
  wire [7:0] w_idx = word_index(aw_addr);
  wire [7:0] r_idx = word_index(araddr);

  reg  next_aw_full;                      // address slot next cycle
  reg  next_w_full;                       // data slot next cycle
  reg  next_r_busy;                       // read answer pending

  // slot occupancy for the next cycle
  always @*
  begin
    next_aw_full = do_write ? 1'b0 : (aw_full | aw_take);
    next_w_full  = do_write ? 1'b0 : (w_full | w_take);
    next_r_busy  = ar_take | (rvalid & ~rready);
  end

  // address mapped for writes
  wire w_mapped = (w_idx >= `ACR_IDX_CTRL_A) & (w_idx <= `ACR_IDX_MISC)
                  & (w_idx != `ACR_IDX_IRQ_STATUS);
  wire r_mapped = (r_idx >= `ACR_IDX_CTRL_A) & (r_idx <= `ACR_IDX_MISC);

  // byte-lane merge of 16-bit registers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  wire [15:0] wr_val = merge16(16'h0000, w_data, w_strb);
  wire wr_a   = do_write & (w_idx == `ACR_IDX_CTRL_A);
  // ctrl_a merged with its own old value, bit 15 handled apart
  wire [15:0] wr_a_val = merge16(ctrl_a, w_data, w_strb);
  wire wr_clr = do_write & (w_idx == `ACR_IDX_IRQ_CLEAR);

  // ==================================================================
  // axi write channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `ACR_RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full;
      wready  <= ~next_w_full;
      if (aw_take)
        aw_addr <= awaddr;
      if (w_take)
      begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      // response once both halves are in
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= w_mapped ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // ==================================================================
  // axi read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `ACR_RESP_OKAY;
    end
    else
    begin
      arready <= ~next_r_busy;
      if (ar_take)
      begin
        rvalid <= 1'b1;
        rresp  <= r_mapped ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
        case (r_idx)
          `ACR_IDX_CTRL_A:     rdata <= {16'h0000, ctrl_a};
          `ACR_IDX_CTRL_B:     rdata <= {16'h0000, ctrl_b};
          `ACR_IDX_CTRL_C:     rdata <= {16'h0000, ctrl_c};
          `ACR_IDX_LOW_EN:     rdata <= {16'h0000, low_en};
          `ACR_IDX_IRQ_STATUS: rdata <= {19'h00000, irq_status};
          `ACR_IDX_IRQ_ENABLE: rdata <= {19'h00000, gpio_ev_en,
                                         low_en[11:0]};
          `ACR_IDX_MISC:       rdata <= {26'h0000000, idle_cnt == 9'h000,
                                         hold_cnt != 9'h000, gpio_sync,
                                         cal_suspend, 1'b0, irq_polarity};
          default:             rdata <= 32'h00000000;
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ==================================================================
  // configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_a       <= `ACR_RST_CTRL_A;
      ctrl_b       <= `ACR_RST_CTRL_B;
      ctrl_c       <= `ACR_RST_CTRL_C;
      low_en       <= `ACR_RST_LOW_EN;
      gpio_ev_en   <= 1'b0;
      irq_polarity <= 1'b0;
    end
    else
    begin
      // restart bit never stays set
      ctrl_a[`ACR_RESTART_BIT] <= 1'b0;
      if (wr_a)
      begin
        ctrl_a[14:0] <= wr_a_val[14:0];
        // restart bit set for one cycle only
        ctrl_a[`ACR_RESTART_BIT] <= wr_val[`ACR_RESTART_BIT];
      end
      if (do_write & (w_idx == `ACR_IDX_CTRL_B))
        ctrl_b <= merge16(ctrl_b, w_data, w_strb);
      if (do_write & (w_idx == `ACR_IDX_CTRL_C))
        ctrl_c <= merge16(ctrl_c, w_data, w_strb);
      if (do_write & (w_idx == `ACR_IDX_LOW_EN))
        low_en <= merge16(low_en, w_data, w_strb);
      if (do_write & (w_idx == `ACR_IDX_IRQ_ENABLE) & w_strb[1])
        gpio_ev_en <= w_data[`ACR_GPIO_EV_BIT];
      if (do_write & (w_idx == `ACR_IDX_MISC) & w_strb[0])
        irq_polarity <= w_data[0];
    end
  end

  // field views
  wire [3:0] skip_field = ctrl_a[`ACR_SKIP_MSB:0];
  wire [3:0] fp_hold    = ctrl_a[`ACR_FP_HOLD_LSB+3:`ACR_FP_HOLD_LSB];
  wire [3:0] lp_hold    = ctrl_a[`ACR_LP_HOLD_LSB+3:`ACR_LP_HOLD_LSB];
  wire [1:0] tmo_sel    = ctrl_a[`ACR_TIMEOUT_LSB+1:`ACR_TIMEOUT_LSB];
  wire [1:0] gpio_setup = low_en[`ACR_GPIO_SETUP_LSB+1:`ACR_GPIO_SETUP_LSB];
  wire [1:0] gpio_trig  = low_en[`ACR_GPIO_TRIG_LSB+1:`ACR_GPIO_TRIG_LSB];

  // skip count limited to its largest legal code
  wire [3:0] skip_lim = (skip_field > `ACR_SKIP_MAX) ? `ACR_SKIP_MAX
                                                     : skip_field;
  // hold lengths in sequences: count x16 or count x4
  wire [8:0] fp_len = {1'b0, fp_hold, 4'h0};
  wire [8:0] lp_len = {3'b000, lp_hold, 2'b00};
  // timeout = (5 + sel) / 4 of full hold = fp_hold x 4 x (5 + sel)
  wire [3:0] tmo_mul = 4'h5 + {2'b00, tmo_sel};
  wire [8:0] tmo_len = {1'b0, fp_hold} * {5'h00, tmo_mul} * 9'h004;

  // ==================================================================
  // fast filter admission and calibration hold
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      skip_cnt           <= 4'h0;
      hold_cnt           <= 9'h000;
      idle_cnt           <= 9'h000;
      fast_admit         <= 1'b0;
      cal_suspend        <= 1'b0;
      power_drop_request <= 1'b0;
    end
    else
    begin
      fast_admit         <= 1'b0;
      power_drop_request <= 1'b0;
      // admit one sequence after skip_lim discarded ones
      if (seq_done)
      begin
        if (skip_cnt >= skip_lim)
        begin
          skip_cnt   <= 4'h0;
          fast_admit <= 1'b1;
        end
        else
          skip_cnt <= skip_cnt + 4'h1;
      end
      // hold reloads while near, counts sequences afterwards
      if (near_detect)
        hold_cnt <= lp_mode ? lp_len : fp_len;
      else if (seq_done & (hold_cnt != 9'h000))
        hold_cnt <= hold_cnt - 9'h001;
      cal_suspend <= near_detect | (hold_cnt != 9'h000);
      // full power idle timeout toward low power
      if (near_detect | lp_mode)
        idle_cnt <= tmo_len;
      else if (seq_done & (idle_cnt != 9'h000))
      begin
        idle_cnt <= idle_cnt - 9'h001;
        if (idle_cnt == 9'h001)
          power_drop_request <= 1'b1;
      end
    end
  end

  // ==================================================================
  // control outputs from registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fast_filter_skip_count     <= 4'h0;
      force_recal                <= 1'b0;
      sequence_restart           <= 1'b0;
      near_recal_level           <= 8'h00;
      near_detect_rate           <= 6'h00;
      slow_average_update_level  <= 2'h0;
      full_power_near_recal_time <= 10'h000;
      low_power_near_recal_time  <= 6'h00;
    end
    else
    begin
      fast_filter_skip_count     <= skip_lim;
      force_recal                <= ctrl_a[`ACR_FORCE_CAL_BIT];
      sequence_restart           <= ctrl_a[`ACR_RESTART_BIT];
      near_recal_level           <= ctrl_b[7:0];
      near_detect_rate           <= ctrl_b[13:8];
      slow_average_update_level  <= ctrl_b[15:14];
      full_power_near_recal_time <= ctrl_c[9:0];
      low_power_near_recal_time  <= ctrl_c[15:10];
    end
  end

  // ==================================================================
  // general-purpose pin
  reg gpio_event;                         // trigger condition met
  always @*
  begin
    case (gpio_trig)
      `ACR_TRIG_LOW:  gpio_event = ~gpio_sync;
      `ACR_TRIG_RISE: gpio_event = gpio_sync & ~gpio_prev;
      `ACR_TRIG_FALL: gpio_event = ~gpio_sync & gpio_prev;
      default:        gpio_event = gpio_sync;
    endcase
  end

  // synchroniser, output drive and enable
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gpio_meta <= 1'b0;
      gpio_sync <= 1'b0;
      gpio_prev <= 1'b0;
      gpio_out  <= 1'b0;
      gpio_oe   <= 1'b0;
    end
    else
    begin
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
      gpio_prev <= gpio_sync;
      gpio_oe   <= gpio_setup[1];
      case (gpio_setup)
        `ACR_GPIO_OUT_LOW:  gpio_out <= ~gpio_assert;
        `ACR_GPIO_OUT_HIGH: gpio_out <= gpio_assert;
        default:            gpio_out <= 1'b0;
      endcase
    end
  end

  // ==================================================================
  // interrupt status, enable and output
  wire [12:0] irq_set;                    // events this cycle
  wire [12:0] irq_mask = {gpio_ev_en, low_en[11:0]};
  genvar gi;
  generate
    for (gi = 0; gi < `ACR_STAGES; gi = gi + 1)
    begin : g_stage
      // disabled stage sources are ignored
      assign irq_set[gi] = stage_low_hit[gi] & low_en[gi];
    end
  endgenerate
  assign irq_set[`ACR_GPIO_EV_BIT] = gpio_event & gpio_ev_en &
                                     (gpio_setup == `ACR_GPIO_IN);

  wire [12:0] clr_bits = wr_clr ? wr_val[12:0] : 13'h0000;
  // set wins over a clear in the same cycle
  wire [12:0] next_status = (irq_status & ~clr_bits) | irq_set;
  wire        irq_active  = |(next_status & irq_mask);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= 13'h0000;
      irq        <= 1'b1;
    end
    else
    begin
      irq_status <= next_status;
      irq        <= irq_polarity ? irq_active : ~irq_active;
    end
  end

endmodule
`default_nettype wire

// [testbench/acr_regs_chk.sv]
// port checker for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        seq_done,
  input wire logic        near_detect,
  input wire logic        fast_admit,
  input wire logic [3:0]  fast_filter_skip_count,
  input wire logic        cal_suspend,
  input wire logic        power_drop_request,
  input wire logic        sequence_restart,
  input wire logic        gpio_out,
  input wire logic        gpio_oe
);
  // ==================================================================
  // one clock domain, synchronous reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write answer two edges after both halves are taken
  property p_b_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("late write answer");
  // answers stand until taken
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("late read answer");
  // ==================================================================
  // function outputs
  property p_admit;
    fast_admit |-> $past(seq_done);
  endproperty
  a_admit: assert property (p_admit) else $error("admit without seq");
  property p_skip_max;
    fast_filter_skip_count <= 4'hB;
  endproperty
  a_skip_max: assert property (p_skip_max) else $error("skip over max");
  property p_near;
    near_detect |=> cal_suspend;
  endproperty
  a_near: assert property (p_near) else $error("no suspend on near");
  property p_drop;
    power_drop_request |=> !power_drop_request;
  endproperty
  a_drop: assert property (p_drop) else $error("drop not a pulse");
  property p_restart;
    sequence_restart |=> !sequence_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("restart stuck");
  property p_gpio_off;
    !gpio_oe |-> !gpio_out;
  endproperty
  a_gpio_off: assert property (p_gpio_off) else $error("pin idle high");
  c_admit: cover property (fast_admit);
  c_drop: cover property (power_drop_request);
  c_restart: cover property (sequence_restart);
endmodule
bind acr_regs acr_regs_chk acr_regs_chk_inst (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .seq_done,
  .near_detect, .fast_admit, .fast_filter_skip_count, .cal_suspend,
  .power_drop_request, .sequence_restart, .gpio_out, .gpio_oe
);
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==================================================================
  // driven inputs
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, seq_done = 1'b0;
  logic lp_mode = 1'b0, near_detect = 1'b0, gpio_in = 1'b0;
  logic gpio_assert = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [11:0] stage_low_hit = 12'h000;
  // observed outputs
  wire logic awready, wready, bvalid, arready, rvalid, fast_admit;
  wire logic cal_suspend, power_drop_request, force_recal;
  wire logic sequence_restart, gpio_out, gpio_oe, irq;
  wire logic [1:0]  bresp, rresp, slow_average_update_level;
  wire logic [31:0] rdata;
  wire logic [3:0]  fast_filter_skip_count;
  wire logic [7:0]  near_recal_level;
  wire logic [5:0]  near_detect_rate, low_power_near_recal_time;
  wire logic [9:0]  full_power_near_recal_time;
  int error_cnt = 0, checks_done = 0;
  int admit_cnt = 0, drop_cnt = 0, rst_cnt = 0;
  logic [1:0]  resp;
  logic [31:0] rd_data;
  acr_regs acr_regs_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .seq_done, .lp_mode, .near_detect,
    .stage_low_hit, .fast_admit, .fast_filter_skip_count, .cal_suspend,
    .power_drop_request, .force_recal, .sequence_restart,
    .near_recal_level, .near_detect_rate, .slow_average_update_level,
    .full_power_near_recal_time, .low_power_near_recal_time, .gpio_in,
    .gpio_assert, .gpio_out, .gpio_oe, .irq
  );
  always #5 aclk = ~aclk;
  // pulse counters for admit, drop and restart
  always @(posedge aclk)
  begin
    if (fast_admit === 1'b1)
      admit_cnt <= admit_cnt + 1;
    if (power_drop_request === 1'b1)
      drop_cnt <= drop_cnt + 1;
    if (sequence_restart === 1'b1)
      rst_cnt <= rst_cnt + 1;
  end
  // ==================================================================
  // helpers
  task stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bounded wait step, gives up the run when spent
  task guard(inout int n);
    n++;
    if (n > 200)
    begin
      chk(32'h1, 32'h0);
      stop_test;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      guard(n);
      if (awready === 1'b1)
        aw = 1'b1;
      if (wready === 1'b1)
        w = 1'b1;
      awvalid <= !aw;
      wvalid <= !w;
    end
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(n);
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(n);
    end
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      guard(n);
    end
    while (rvalid !== 1'b1);
    rd_data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_data, e);
    chk(resp, 32'h0);
  endtask
  task seq(input int n);
    repeat (n)
    begin
      seq_done <= 1'b1;
      @(posedge aclk);
      seq_done <= 1'b0;
      tick(2);
    end
  endtask
  task near_pulse;
    near_detect <= 1'b1;
    tick(1);
    near_detect <= 1'b0;
    tick(2);
  endtask
  // ==================================================================
  // scenarios
  task t_reset;
    rdc(8'h08, 32'h0FF0);
    rdc(8'h0C, 32'h0140);
    rdc(8'h10, 32'hFFFF);
    rdc(8'h14, 32'h0000);
    chk(irq, 32'h1);
  endtask
  task t_fields;
    wr(8'h0C, 32'hC5A7);
    rdc(8'h0C, 32'hC5A7);
    chk({slow_average_update_level, near_detect_rate, near_recal_level},
        32'hC5A7);
    wr(8'h10, 32'h1234);
    rdc(8'h10, 32'h1234);
    chk({low_power_near_recal_time, full_power_near_recal_time},
        32'h1234);
  endtask
  task t_ctrl_a;
    int r0;
    r0 = rst_cnt;
    wr(8'h08, 32'hC0F0);
    tick(3);
    chk(rst_cnt - r0, 32'h1);
    chk(force_recal, 32'h1);
    rdc(8'h08, 32'h40F0);
    wr(8'h08, 32'h00F0);
    tick(3);
    chk(force_recal, 32'h0);
    chk(rst_cnt - r0, 32'h1);
  endtask
  // admit every skip+1 sequences, over-range skip limited
  task t_skip;
    int a0, s;
    for (int i = 0; i < 3; i++)
    begin
      s = (i == 0) ? 0 : (i == 1) ? 2 : 11;
      wr(8'h08, 32'h0FF0 | s);
      a0 = admit_cnt;
      seq(12);
      chk(admit_cnt - a0, 12 / (s + 1));
    end
    wr(8'h08, 32'h0FFF);
    tick(3);
    chk(fast_filter_skip_count, 32'hB);
  endtask
  // hold of 16 sequences, drop after 4*(5+sel) sequences
  task t_hold;
    int d0;
    for (int sel = 0; sel < 4; sel++)
    begin
      wr(8'h08, (sel << 12) | 32'h0110);
      near_pulse;
      d0 = drop_cnt;
      seq(15);
      chk(cal_suspend, 32'h1);
      seq(1);
      chk(cal_suspend, 32'h0);
      seq(4 * (5 + sel) - 17);
      chk(drop_cnt - d0, 32'h0);
      seq(1);
      chk(drop_cnt - d0, 32'h1);
    end
    lp_mode <= 1'b1;
    near_pulse;
    seq(3);
    chk(cal_suspend, 32'h1);
    seq(1);
    chk(cal_suspend, 32'h0);
    lp_mode <= 1'b0;
  endtask
  task t_irq;
    wr(8'h14, 32'h0008);
    stage_low_hit <= 12'h004;
    tick(3);
    chk(irq, 32'h1);
    rdc(8'h18, 32'h0);
    stage_low_hit <= 12'h008;
    tick(3);
    chk(irq, 32'h0);
    rdc(8'h18, 32'h8);
    stage_low_hit <= 12'h000;
    wr(8'h1C, 32'h8);
    tick(2);
    chk(irq, 32'h1);
    wr(8'h24, 32'h1);
    tick(2);
    chk(irq, 32'h0);
    stage_low_hit <= 12'h008;
    tick(3);
    chk(irq, 32'h1);
    stage_low_hit <= 12'h000;
    wr(8'h1C, 32'h8);
    tick(2);
    chk(irq, 32'h0);
  endtask
  task t_gpio_setup;
    for (int s = 0; s < 4; s++)
      for (int a = 0; a < 2; a++)
      begin
        wr(8'h14, s << 12);
        gpio_assert <= a[0];
        tick(3);
        chk({gpio_oe, gpio_out}, {s[1], s[1] & (s[0] ~^ a[0])});
      end
  endtask
  // high, clear, low, high again: sticky event per trigger code
  task t_gpio_trig;
    wr(8'h20, 32'h1000);
    rdc(8'h20, 32'h1000);
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h14, (t << 14) | 32'h1000);
      gpio_in <= 1'b1;
      tick(6);
      wr(8'h1C, 32'h1000);
      tick(2);
      rdc(8'h18, (t == 3) ? 32'h1000 : 32'h0);
      gpio_in <= 1'b0;
      tick(6);
      rdc(8'h18, (t != 1) ? 32'h1000 : 32'h0);
      gpio_in <= 1'b1;
      tick(6);
      rdc(8'h18, 32'h1000);
    end
  endtask
  task t_bad;
    wr(8'h04, 32'hFFFF);
    chk(resp, 32'h2);
    rd(8'h28);
    chk(resp, 32'h2);
    chk(rd_data, 32'h0);
    wr(8'h18, 32'h1);
    chk(resp, 32'h2);
    rdc(8'h1C, 32'h0);
  endtask
  initial
  begin
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    t_reset;
    t_fields;
    t_ctrl_a;
    t_skip;
    t_hold;
    t_irq;
    t_gpio_setup;
    t_gpio_trig;
    t_bad;
    stop_test;
  end
endmodule
`default_nettype wire
